// [design/dsgb_pkg.sv]
package dsgb_pkg;
   // Clock and back-channel timing
   localparam int CLK_HZ = 100_000_000;
   localparam int BC_FAST_BPS = 20_000_000;
   localparam int BC_BASE_CYCLES = CLK_HZ / BC_FAST_BPS;
   localparam logic [3:0] BC_BASE_LAST = 4'(BC_BASE_CYCLES - 1);
   // Divider codes hold the divide ratio minus one
   localparam logic [1:0] BC_DIV1 = 2'h0;
   localparam logic [1:0] BC_DIV2 = 2'h1;
   localparam logic [1:0] BC_DIV4 = 2'h3;

   // Register indices; the byte address is four times the index
   localparam logic [7:0] REG_OUTPUT_CONTROL = 8'h02;
   localparam logic [7:0] REG_GPIO0_CONFIG = 8'h1d;
   localparam logic [7:0] REG_GPIO1_GPIO2_CONFIG = 8'h1e;
   localparam logic [7:0] REG_GPIO3_CONFIG = 8'h1f;
   localparam logic [7:0] REG_BC_RATE_CONFIG = 8'h23;
   localparam logic [7:0] REG_LANE_SELECT = 8'h34;
   localparam logic [7:0] REG_FAST_CHANNEL_CONTROL = 8'h43;
   localparam logic [7:0] REG_LINK_CONTROL = 8'h50;
   localparam logic [7:0] REG_LINK_STATUS = 8'h51;
   localparam logic [7:0] REG_GPIO_LEVEL = 8'h6e;

   // Field positions
   localparam int OC_OUTPUT_ENABLE_BIT = 7;
   localparam int OC_OSC_ENABLE_BIT = 5;
   localparam int OC_SLEEP_SELECT_BIT = 4;
   localparam int BC_DIV_SELECT_BIT = 6;
   localparam int BC_FAST_ENABLE_BIT = 4;
   localparam int LC_IRQ_FORWARD_BIT = 0;

   // Values after reset
   localparam logic [7:0] OUTPUT_CONTROL_RESET = 8'h90;
   localparam logic [7:0] GPIO_CONFIG_RESET = 8'h00;
   localparam logic [7:0] BC_RATE_RESET = 8'h00;
   localparam logic [1:0] LANE_SELECT_RESET = 2'h1;
   localparam logic [2:0] FAST_MODE_RESET = 3'h0;
   localparam logic [7:0] LINK_CONTROL_RESET = 8'h00;
   localparam logic [2:0] STRAP_SETTLE = 3'h5;

   // GPIO configuration nibble codes
   localparam logic [3:0] GPIO_CODE_FORWARD = 4'h5;
   localparam logic [3:0] GPIO_CODE_BACK = 4'h3;
   localparam logic [3:0] GPIO_CODE_LOCAL_LOW = 4'h1;
   localparam logic [3:0] GPIO_CODE_LOCAL_HIGH = 4'h9;

   // Fast control-channel modes
   localparam logic [2:0] FCM_NORMAL = 3'h0;
   localparam logic [2:0] FCM_ONE_GPIO = 3'h1;
   localparam logic [2:0] FCM_TWO_GPIO = 3'h2;
   localparam logic [2:0] FCM_FOUR_GPIO = 3'h3;

   // AXI responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {
      DSGB_OFF = 2'h0,
      DSGB_ACQUIRE = 2'h1,
      DSGB_LOCKED = 2'h3
   } dsgb_lock_state_type;

   typedef enum logic [1:0] {
      DSGB_DRIVE_Z = 2'h0,
      DSGB_DRIVE_LOW = 2'h1,
      DSGB_DRIVE_VALID = 2'h2
   } dsgb_drive_type;
endpackage

// [design/dsgb_bc_if.sv]
`timescale 1ns/10ps
`default_nettype none
// Rate selection and back-channel ticks between control and divider
interface dsgb_bc_if;
   logic [1:0] div_code;
   logic bit_tick;
   logic osc_clk;
   modport ctrl (output div_code, input bit_tick, input osc_clk);
   modport gen (input div_code, output bit_tick, output osc_clk);
endinterface
`default_nettype wire

// [design/dsgb_pin_sync.sv]
`timescale 1ns/10ps
`default_nettype none
module dsgb_pin_sync #(
   parameter int WIDTH = 1
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [WIDTH-1:0] pin,
   output logic [WIDTH-1:0] level
);
   logic [WIDTH-1:0] s1_reg;
   logic [WIDTH-1:0] s2_reg;
   logic [WIDTH-1:0] s3_reg;
   logic [WIDTH-1:0] level_reg;
   wire [WIDTH-1:0] agree = ~(s2_reg ^ s3_reg);

   // Three stages; a change counts once the last two agree
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s1_reg <= '0;
         s2_reg <= '0;
         s3_reg <= '0;
         level_reg <= '0;
      end else begin
         s1_reg <= pin;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         level_reg <= (agree & s3_reg) | (~agree & level_reg);
      end
   end
   assign level = level_reg;
endmodule // dsgb_pin_sync
`default_nettype wire

// [design/dsgb_bc_divider.sv]
`timescale 1ns/10ps
`default_nettype none
module dsgb_bc_divider import dsgb_pkg::*; (
   input wire logic aclk,
   input wire logic aresetn,
   dsgb_bc_if.gen bc
);
   logic [3:0] base_reg;
   logic [1:0] sub_reg;
   logic tick_reg;
   logic osc_reg;
   wire base_tick = (base_reg == BC_BASE_LAST);
   wire sub_last = (sub_reg >= bc.div_code);

   // Oscillator base rate, then divide by 1, 2 or 4
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         base_reg <= 4'h0;
         sub_reg <= 2'h0;
         tick_reg <= 1'b0;
         osc_reg <= 1'b0;
      end else begin
         base_reg <= base_tick ? 4'h0 : base_reg + 4'h1;
         if (base_tick) begin
            sub_reg <= sub_last ? 2'h0 : sub_reg + 2'h1;
            osc_reg <= ~osc_reg;
         end
         tick_reg <= base_tick & sub_last;
      end
   end
   assign bc.bit_tick = tick_reg;
   assign bc.osc_clk = osc_reg;
endmodule // dsgb_bc_divider
`default_nettype wire

// [design/dsgb_top.sv]
// What this block does
// - Port select steers access to duplicated sets
// - Read returns selected copy, second if both
// - Write updates every selected port copy
// - Lost input plus enable drives oscillator clock when sleep bit clear
// - Power up starts lock; indicator held low
// - Lock complete drives lock indicator high when sleep bit set
// - Power-down floats all but interrupt pin; sleep bit picks state
// - Output enable: valid only active and sleep
// - Low power-down input powers down device
// - Forward local interrupt input across link
// - Interrupt pin may pull low in power-down
// - GPIO nibble picks forward output or input
// - Same config registers serve either lane
// - Second-lane GPIOs only in two-lane mode
// - GPIO levels readable; local output modes
// - Divider select: divide four or two
// - Fast bit or strap forces divide one
// - Fast mode replaces normal back-channel signalling
// - Mode field sets second-lane GPIO count and samples
`timescale 1ns/10ps
`default_nettype none
module dsgb_top import dsgb_pkg::*; (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [9:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [9:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic power_down_n,
   input wire logic serial_active,
   input wire logic lock_done,
   input wire logic two_lane_mode,
   input wire logic strap_mode_select,
   output logic lock_out,
   output logic lock_oe,
   output logic data_oe,
   output logic data_valid,
   output logic video_oe,
   output logic video_valid,
   output logic video_osc_sel,
   output logic osc_clk,
   input wire logic [3:0] gpio_in,
   output logic [3:0] gpio_out,
   output logic [3:0] gpio_oe,
   input wire logic [3:0] dgpio_in,
   output logic [3:0] dgpio_out,
   output logic [3:0] dgpio_oe,
   input wire logic [3:0] fwd_gpio,
   input wire logic [3:0] fwd_dgpio,
   output logic [3:0] bc_gpio,
   output logic [3:0] bc_dgpio,
   output logic [3:0] bc_dgpio_mask,
   output logic [3:0] bc_samples_per_frame,
   output logic bc_normal_signalling,
   output logic [2:0] fast_channel_mode,
   output logic bc_bit_tick,
   input wire logic remote_irq_input_n_in,
   output logic remote_irq_input_n_out,
   output logic remote_irq_input_n_oe,
   output logic irq_to_link
);
   // Register index decode shared by both address channels
   function automatic logic [7:0] reg_index(input logic [9:0] addr);
      return addr[9:2];
   endfunction

   function automatic logic is_mapped(input logic [7:0] idx);
      return idx == REG_OUTPUT_CONTROL || idx == REG_GPIO0_CONFIG ||
         idx == REG_GPIO1_GPIO2_CONFIG || idx == REG_GPIO3_CONFIG ||
         idx == REG_BC_RATE_CONFIG || idx == REG_LANE_SELECT ||
         idx == REG_FAST_CHANNEL_CONTROL || idx == REG_LINK_CONTROL ||
         idx == REG_LINK_STATUS || idx == REG_GPIO_LEVEL;
   endfunction

   // Configuration nibble of one pin
   function automatic logic [3:0] pin_code(input logic [7:0] c0,
         input logic [7:0] c1, input logic [7:0] c2, input int pin);
      case (pin)
         0: return c0[3:0];
         1: return c1[3:0];
         2: return c1[7:4];
         default: return c2[3:0];
      endcase
   endfunction

   // Synchronised pins; interrupt inverted so reset reads idle
   logic [12:0] sync_level;
   logic pdn_s, serial_s, lockd_s, strap_s, irq_s;
   logic [3:0] gpio_s, dgpio_s;
   dsgb_pin_sync #(.WIDTH(13)) u_sync (
      .aclk(aclk),
      .aresetn(aresetn),
      .pin({dgpio_in, gpio_in, ~remote_irq_input_n_in, strap_mode_select,
            lock_done, serial_active, power_down_n}),
      .level(sync_level)
   );
   assign {dgpio_s, gpio_s, irq_s, strap_s, lockd_s, serial_s, pdn_s} =
      sync_level;

   // Registers
   logic [7:0] output_control_reg;
   logic [7:0] gpio_cfg_reg [2][3];
   logic [7:0] bc_rate_reg;
   logic [1:0] lane_select_reg;
   logic [2:0] fast_mode_reg;
   logic [7:0] link_control_reg;
   logic strap_fast_reg;
   logic [2:0] strap_cnt_reg;
   dsgb_lock_state_type lock_state_reg, lock_state_next;

   // AXI slave state
   logic aw_held_reg, w_held_reg, w_lane0_reg;
   logic [7:0] aw_idx_reg, w_data_reg;
   logic bvalid_reg, rvalid_reg;
   logic [1:0] bresp_reg, rresp_reg;
   logic [7:0] rdata_reg;

   // Write and read channel handshakes
   wire aw_fire = s_axi_awvalid & s_axi_awready;
   wire w_fire = s_axi_wvalid & s_axi_wready;
   wire ar_fire = s_axi_arvalid & s_axi_arready;
   wire do_write = aw_held_reg & w_held_reg & ~bvalid_reg;
   wire wr_mapped = is_mapped(aw_idx_reg);
   wire wr_en = do_write & w_lane0_reg;
   wire [7:0] rd_idx = reg_index(s_axi_araddr);
   assign s_axi_awready = ~aw_held_reg & ~bvalid_reg;
   assign s_axi_wready = ~w_held_reg & ~bvalid_reg;
   assign s_axi_arready = ~rvalid_reg;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_reg <= 1'b0;
         w_held_reg <= 1'b0;
         aw_idx_reg <= 8'h00;
         w_data_reg <= 8'h00;
         w_lane0_reg <= 1'b0;
         bvalid_reg <= 1'b0;
         bresp_reg <= RESP_OKAY;
      end else begin
         if (aw_fire) begin
            aw_held_reg <= 1'b1;
            aw_idx_reg <= reg_index(s_axi_awaddr);
         end
         if (w_fire) begin
            w_held_reg <= 1'b1;
            w_data_reg <= s_axi_wdata[7:0];
            w_lane0_reg <= s_axi_wstrb[0];
         end
         if (do_write) begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            bvalid_reg <= 1'b1;
            bresp_reg <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_bready) begin
            bvalid_reg <= 1'b0;
         end
      end
   end
   assign s_axi_bvalid = bvalid_reg;
   assign s_axi_bresp = bresp_reg;

   wire fast_active = bc_rate_reg[BC_FAST_ENABLE_BIT] | strap_fast_reg;

   // Selected copy of a duplicated register
   wire rd_port1 = lane_select_reg[1];
   logic [7:0] rd_byte;
   wire [3:0] lane0_level = gpio_s;
   wire [3:0] lane1_level = dgpio_s & {4{two_lane_mode}};
   wire [7:0] status_byte = {1'b0, strap_fast_reg, fast_active,
      irq_s, serial_s, pdn_s, lock_state_reg};

   always_comb begin
      rd_byte = 8'h00;
      unique case (rd_idx)
         REG_OUTPUT_CONTROL: rd_byte = output_control_reg;
         REG_GPIO0_CONFIG: rd_byte = gpio_cfg_reg[rd_port1][0];
         REG_GPIO1_GPIO2_CONFIG: rd_byte = gpio_cfg_reg[rd_port1][1];
         REG_GPIO3_CONFIG: rd_byte = gpio_cfg_reg[rd_port1][2];
         REG_BC_RATE_CONFIG: rd_byte = bc_rate_reg;
         REG_LANE_SELECT: rd_byte = {6'h00, lane_select_reg};
         REG_FAST_CHANNEL_CONTROL: rd_byte = {5'h00, fast_mode_reg};
         REG_LINK_CONTROL: rd_byte = link_control_reg;
         REG_LINK_STATUS: rd_byte = status_byte;
         REG_GPIO_LEVEL: rd_byte = {lane1_level, lane0_level};
         default: rd_byte = 8'h00;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_reg <= 1'b0;
         rdata_reg <= 8'h00;
         rresp_reg <= RESP_OKAY;
      end else if (ar_fire) begin
         rvalid_reg <= 1'b1;
         rdata_reg <= rd_byte;
         rresp_reg <= is_mapped(rd_idx) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
         rvalid_reg <= 1'b0;
      end
   end
   assign s_axi_rvalid = rvalid_reg;
   assign s_axi_rdata = {24'h000000, rdata_reg};
   assign s_axi_rresp = rresp_reg;

   // Shared registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         output_control_reg <= OUTPUT_CONTROL_RESET;
         bc_rate_reg <= BC_RATE_RESET;
         lane_select_reg <= LANE_SELECT_RESET;
         fast_mode_reg <= FAST_MODE_RESET;
         link_control_reg <= LINK_CONTROL_RESET;
      end else if (wr_en) begin
         if (aw_idx_reg == REG_OUTPUT_CONTROL)
            output_control_reg <= w_data_reg;
         if (aw_idx_reg == REG_BC_RATE_CONFIG)
            bc_rate_reg <= w_data_reg;
         if (aw_idx_reg == REG_LANE_SELECT)
            lane_select_reg <= w_data_reg[1:0];
         if (aw_idx_reg == REG_FAST_CHANNEL_CONTROL)
            fast_mode_reg <= w_data_reg[2:0];
         if (aw_idx_reg == REG_LINK_CONTROL)
            link_control_reg <= w_data_reg;
      end
   end

   // Duplicated GPIO configuration, one copy per lane
   generate
      for (genvar p = 0; p < 2; p++) begin : g_port
         for (genvar k = 0; k < 3; k++) begin : g_cfg
            wire hit = wr_en && lane_select_reg[p] &&
               aw_idx_reg == REG_GPIO0_CONFIG + 8'(k);
            always_ff @(posedge aclk) begin
               if (!aresetn)
                  gpio_cfg_reg[p][k] <= GPIO_CONFIG_RESET;
               else if (hit)
                  gpio_cfg_reg[p][k] <= w_data_reg;
            end
         end
      end
   endgenerate

   // Mode strap caught once the pin synchroniser has settled
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         strap_cnt_reg <= 3'h0;
         strap_fast_reg <= 1'b0;
      end else if (strap_cnt_reg != STRAP_SETTLE) begin
         strap_cnt_reg <= strap_cnt_reg + 3'h1;
         if (strap_cnt_reg == STRAP_SETTLE - 3'h1)
            strap_fast_reg <= strap_s;
      end
   end

   // Back-channel rate selection
   dsgb_bc_if bc_link ();
   assign bc_link.div_code = fast_active ? BC_DIV1 :
      (bc_rate_reg[BC_DIV_SELECT_BIT] ? BC_DIV2 : BC_DIV4);
   dsgb_bc_divider u_div (
      .aclk(aclk),
      .aresetn(aresetn),
      .bc(bc_link)
   );
   assign bc_bit_tick = bc_link.bit_tick;
   assign osc_clk = bc_link.osc_clk;

   // Lock sequence
   always_comb begin
      lock_state_next = lock_state_reg;
      unique case (lock_state_reg)
         DSGB_OFF:
            if (pdn_s) lock_state_next = DSGB_ACQUIRE;
         DSGB_ACQUIRE:
            if (serial_s && lockd_s) lock_state_next = DSGB_LOCKED;
         DSGB_LOCKED:
            if (!serial_s || !lockd_s)
               lock_state_next = DSGB_ACQUIRE;
         default: lock_state_next = DSGB_OFF;
      endcase
      if (!pdn_s) lock_state_next = DSGB_OFF;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) lock_state_reg <= DSGB_OFF;
      else lock_state_reg <= lock_state_next;
   end

   // Output state table
   wire oc_en = output_control_reg[OC_OUTPUT_ENABLE_BIT];
   wire oc_sleep = output_control_reg[OC_SLEEP_SELECT_BIT];
   wire oc_osc = output_control_reg[OC_OSC_ENABLE_BIT];
   wire locked = lock_state_reg == DSGB_LOCKED;
   wire run_valid = oc_en & oc_sleep & serial_s & locked;
   dsgb_drive_type drive_mode;
   assign drive_mode = !pdn_s ? DSGB_DRIVE_Z :
      (!oc_en && oc_sleep) ? DSGB_DRIVE_Z :
      run_valid ? DSGB_DRIVE_VALID : DSGB_DRIVE_LOW;
   wire lock_oe_next = pdn_s;
   wire lock_next = run_valid | (!oc_en & oc_sleep & locked);
   wire osc_sel_next = pdn_s & oc_en & !oc_sleep & !serial_s & oc_osc;

   // GPIO pin behaviour per lane
   logic [3:0] lane_in [2];
   logic [3:0] lane_fwd [2];
   logic [3:0] pin_oe_next [2];
   logic [3:0] pin_out_next [2];
   logic [3:0] pin_back [2];
   assign lane_in[0] = gpio_s;
   assign lane_in[1] = dgpio_s;
   assign lane_fwd[0] = fwd_gpio;
   assign lane_fwd[1] = fwd_dgpio;
   generate
      for (genvar l = 0; l < 2; l++) begin : g_lane
         wire lane_on = (l == 0) | two_lane_mode;
         for (genvar i = 0; i < 4; i++) begin : g_pin
            wire [3:0] code = pin_code(gpio_cfg_reg[l][0],
               gpio_cfg_reg[l][1], gpio_cfg_reg[l][2], i);
            wire is_fwd = code == GPIO_CODE_FORWARD;
            wire is_hi = code == GPIO_CODE_LOCAL_HIGH;
            wire is_out = is_fwd | is_hi | code == GPIO_CODE_LOCAL_LOW;
            wire val = is_fwd ? lane_fwd[l][i] : is_hi;
            assign pin_oe_next[l][i] = lane_on &&
               (drive_mode == DSGB_DRIVE_LOW ||
               (drive_mode == DSGB_DRIVE_VALID && is_out));
            assign pin_out_next[l][i] = drive_mode == DSGB_DRIVE_VALID &&
               is_out && val;
            assign pin_back[l][i] = lane_on && code == GPIO_CODE_BACK &&
               lane_in[l][i];
         end
      end
   endgenerate

   // Back-channel carriage by fast-channel mode
   logic [3:0] mode_mask, mode_samples;
   always_comb begin
      mode_mask = 4'h0;
      mode_samples = 4'h0;
      unique case (fast_mode_reg)
         FCM_NORMAL: begin
            mode_mask = 4'hf;
            mode_samples = 4'h1;
         end
         FCM_FOUR_GPIO: begin
            mode_mask = 4'hf;
            mode_samples = 4'h6;
         end
         FCM_TWO_GPIO: begin
            mode_mask = 4'h3;
            mode_samples = 4'ha;
         end
         FCM_ONE_GPIO: begin
            mode_mask = 4'h1;
            mode_samples = 4'hf;
         end
         default: begin
            mode_mask = 4'h0;
            mode_samples = 4'h0;
         end
      endcase
   end
   wire [3:0] dmask = mode_mask & {4{two_lane_mode}};

   // Interrupt forwarding and power-down pull-low
   wire irq_fwd_en = link_control_reg[LC_IRQ_FORWARD_BIT];
   wire irq_next = irq_fwd_en & pdn_s & irq_s;

   // Registered pin and link outputs
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         lock_out <= 1'b0;
         lock_oe <= 1'b0;
         data_oe <= 1'b0;
         data_valid <= 1'b0;
         video_oe <= 1'b0;
         video_valid <= 1'b0;
         video_osc_sel <= 1'b0;
         gpio_oe <= 4'h0;
         gpio_out <= 4'h0;
         dgpio_oe <= 4'h0;
         dgpio_out <= 4'h0;
         bc_gpio <= 4'h0;
         bc_dgpio <= 4'h0;
         bc_dgpio_mask <= 4'h0;
         bc_samples_per_frame <= 4'h0;
         bc_normal_signalling <= 1'b1;
         fast_channel_mode <= 3'h0;
         remote_irq_input_n_oe <= 1'b0;
         irq_to_link <= 1'b0;
      end else begin
         lock_out <= lock_oe_next & lock_next;
         lock_oe <= lock_oe_next;
         data_oe <= drive_mode != DSGB_DRIVE_Z;
         data_valid <= drive_mode == DSGB_DRIVE_VALID;
         video_oe <= drive_mode != DSGB_DRIVE_Z;
         video_valid <= drive_mode == DSGB_DRIVE_VALID;
         video_osc_sel <= osc_sel_next;
         gpio_oe <= pin_oe_next[0];
         gpio_out <= pin_out_next[0];
         dgpio_oe <= pin_oe_next[1];
         dgpio_out <= pin_out_next[1];
         bc_gpio <= pin_back[0];
         bc_dgpio <= pin_back[1] & dmask;
         bc_dgpio_mask <= dmask;
         bc_samples_per_frame <= mode_samples;
         bc_normal_signalling <= fast_mode_reg == FCM_NORMAL;
         fast_channel_mode <= fast_mode_reg;
         remote_irq_input_n_oe <= ~pdn_s;
         irq_to_link <= irq_next;
      end
   end
   assign remote_irq_input_n_out = 1'b0;
endmodule // dsgb_top
`default_nettype wire

// [verif/dsgb_serializer_model.sv]
`timescale 1ns/10ps
`default_nettype none
module dsgb_serializer_model (
   input wire logic aclk,
   input wire logic [3:0] send,
   input wire logic irq_to_link,
   output logic [3:0] fwd_gpio,
   output logic [3:0] fwd_dgpio,
   output logic serializer_irq_n
);
   // Forward frame data and interrupt output, one clock late
   always_ff @(posedge aclk) begin
      fwd_gpio <= send;
      fwd_dgpio <= ~send;
      serializer_irq_n <= !irq_to_link;
   end
endmodule // dsgb_serializer_model
`default_nettype wire

// [verif/dsgb_top_asserts.sv]
`timescale 1ns/10ps
`default_nettype none
module dsgb_top_asserts import dsgb_pkg::*; (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic power_down_n,
   input wire logic serial_active,
   input wire logic lock_done,
   input wire logic lock_out,
   input wire logic lock_oe,
   input wire logic data_oe,
   input wire logic data_valid,
   input wire logic video_oe,
   input wire logic video_osc_sel,
   input wire logic bc_bit_tick,
   input wire logic [2:0] fast_channel_mode,
   input wire logic [3:0] bc_samples_per_frame,
   input wire logic bc_normal_signalling,
   input wire logic remote_irq_input_n_oe
);
   // One clock domain
   default clocking @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   a_pd_floats: assert property (!power_down_n [*8] |->
      !lock_oe && !data_oe && !video_oe) else $error("pd float");
   a_irq_pin_pd: assert property (!power_down_n [*8] |->
      remote_irq_input_n_oe) else $error("irq pin");
   a_lock_cause: assert property ($rose(lock_out) |->
      $past(lock_done, 3) && $past(serial_active, 3)) else $error("lock");
   a_valid_locked: assert property (data_valid |->
      lock_out && lock_oe) else $error("valid");
   a_osc_static: assert property (video_osc_sel |->
      !lock_out && !data_valid) else $error("osc");
   a_tick_gap: assert property (bc_bit_tick |=>
      !bc_bit_tick [*4]) else $error("tick");
   a_mode_normal: assert property ($stable(fast_channel_mode) [*2] |->
      bc_normal_signalling == (fast_channel_mode == FCM_NORMAL))
      else $error("normal");
   a_one_gpio: assert property (fast_channel_mode == FCM_ONE_GPIO [*2] |->
      bc_samples_per_frame == 4'hf) else $error("spf");
   c_lock: cover property ($rose(lock_out));
   c_osc: cover property ($rose(video_osc_sel));
   c_four: cover property (fast_channel_mode == FCM_FOUR_GPIO);
endmodule // dsgb_top_asserts
bind dsgb_top dsgb_top_asserts dsgb_top_asserts_i (.*);
`default_nettype wire

// [verif/dsgb_bench.sv]
`timescale 1ns/10ps
`default_nettype none
module dsgb_bench import dsgb_pkg::*;;
   logic aclk = '0, aresetn = '0, s_axi_awvalid = '0, s_axi_wvalid = '0;
   logic s_axi_bready = '0, s_axi_arvalid = '0, s_axi_rready = '0;
   logic [9:0] s_axi_awaddr = '0, s_axi_araddr = '0;
   logic [2:0] s_axi_awprot = '0, s_axi_arprot = '0, fast_channel_mode;
   logic [31:0] s_axi_wdata = '0, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'hf, gpio_in = '0, dgpio_in = '0, send = '0;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid, power_down_n = '0, serial_active = '0;
   logic lock_done = '0, two_lane_mode = '1, strap_mode_select = '0;
   logic remote_irq_input_n_in = '1, serializer_irq_n, irq_to_link;
   logic lock_out, lock_oe, data_oe, data_valid, video_oe, video_valid;
   logic video_osc_sel, osc_clk, bc_normal_signalling, bc_bit_tick;
   logic remote_irq_input_n_out, remote_irq_input_n_oe;
   logic [3:0] fwd_gpio, fwd_dgpio, gpio_out, gpio_oe, dgpio_out;
   logic [3:0] dgpio_oe, bc_gpio, bc_dgpio, bc_dgpio_mask;
   logic [3:0] bc_samples_per_frame, spf[4] = '{4'h1, 4'hf, 4'ha, 4'h6};
   logic [3:0] msk[4] = '{4'hf, 4'h1, 4'h3, 4'hf};
   logic [7:0] rate[3] = '{8'h00, 8'h40, 8'h50};
   int fails = 0, compares = 0, n, cfg[2];
   // Clock
   always #5 aclk = ~aclk;
   dsgb_top dsgb_top_i (.*);
   dsgb_serializer_model dsgb_serializer_model_i (.*);
   // Verdict
   task automatic report_and_stop;
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // Value comparison
   task automatic chk(input logic [31:0] got, exp, input string m);
      compares++;
      if (got !== exp) begin
         fails++;
         $display("unexpected at %0t: %s got %h", $time, m, got);
      end
   endtask
   // Bounded wait for a level
   task automatic wt(ref logic s, input logic v);
      #1;
      for (n = 0; s !== v; n++) begin
         if (n == 300) begin
            fails++;
            report_and_stop;
         end
         @(posedge aclk);
         #1;
      end
   endtask
   // One register write or read
   task automatic acc(input logic we, input logic [7:0] i, d,
                      input logic [1:0] r);
      logic a, w;
      @(posedge aclk);
      s_axi_awaddr <= {i, 2'h0};
      s_axi_araddr <= {i, 2'h0};
      s_axi_wdata <= {24'h0, d};
      s_axi_awvalid <= we;
      s_axi_wvalid <= we;
      s_axi_bready <= we;
      s_axi_arvalid <= !we;
      s_axi_rready <= !we;
      for (n = 0; n < 300; n++) begin
         @(negedge aclk);
         a = we ? s_axi_awready : s_axi_arready;
         w = s_axi_wready;
         if (we ? s_axi_bvalid : s_axi_rvalid) begin
            chk(we ? s_axi_bresp : s_axi_rresp, r, "resp");
            if (!we) chk(s_axi_rdata, {24'h0, d}, "data");
            @(posedge aclk);
            s_axi_bready <= '0;
            s_axi_rready <= '0;
            return;
         end
         @(posedge aclk);
         if (a) s_axi_awvalid <= '0;
         if (a) s_axi_arvalid <= '0;
         if (w) s_axi_wvalid <= '0;
      end
      fails++;
      report_and_stop;
   endtask
   // Main sequence
   initial begin
      void'($urandom(32'h424960ff));
      repeat (10) @(posedge aclk);
      aresetn <= '1;
      acc(0, REG_OUTPUT_CONTROL, OUTPUT_CONTROL_RESET, RESP_OKAY);
      acc(0, REG_LANE_SELECT, 8'h01, RESP_OKAY);
      acc(0, 8'h07, 8'h00, RESP_SLVERR);
      for (int k = 3; k > 0; k--) begin
         acc(1, REG_LANE_SELECT, 8'(k), RESP_OKAY);
         acc(1, REG_GPIO0_CONFIG, 8'(k), RESP_OKAY);
         if (k & 1) cfg[0] = k;
         if (k & 2) cfg[1] = k;
      end
      for (int k = 3; k >= 0; k--) begin
         acc(1, REG_LANE_SELECT, 8'(k), RESP_OKAY);
         acc(0, REG_GPIO0_CONFIG, 8'(cfg[k > 1]), RESP_OKAY);
      end
      acc(1, REG_LANE_SELECT, 8'h01, RESP_OKAY);
      power_down_n <= '1;
      serial_active <= '1;
      lock_done <= '1;
      send <= 4'($urandom);
      gpio_in <= 4'($urandom);
      dgpio_in <= 4'($urandom);
      wt(lock_out, 1'b1);
      acc(1, REG_GPIO0_CONFIG, GPIO_CODE_FORWARD, RESP_OKAY);
      acc(1, REG_GPIO3_CONFIG, GPIO_CODE_BACK, RESP_OKAY);
      repeat (8) @(posedge aclk);
      #1;
      chk({lock_oe, data_valid, video_valid}, 3'h7, "row");
      chk({gpio_oe[0], gpio_out[0]}, {1'b1, send[0]}, "fwd");
      chk(bc_gpio[3], gpio_in[3], "back");
      acc(0, REG_GPIO_LEVEL, {dgpio_in, gpio_in}, RESP_OKAY);
      foreach (rate[k]) begin
         acc(1, REG_BC_RATE_CONFIG, rate[k], RESP_OKAY);
         repeat (2) begin
            wt(bc_bit_tick, 1'b1);
            wt(bc_bit_tick, 1'b0);
         end
         wt(bc_bit_tick, 1'b1);
         chk(n + 1, 20 >> k, "rate");
      end
      foreach (spf[k]) begin
         acc(1, REG_FAST_CHANNEL_CONTROL, 8'(k), RESP_OKAY);
         repeat (3) @(posedge aclk);
         #1;
         chk({bc_normal_signalling, bc_samples_per_frame,
             bc_dgpio_mask}, {k == 0, spf[k], msk[k]}, "mode");
      end
      acc(1, REG_LINK_CONTROL, 8'h01, RESP_OKAY);
      remote_irq_input_n_in <= '0;
      wt(serializer_irq_n, 1'b0);
      @(posedge aclk);
      serial_active <= '0;
      wt(lock_out, 1'b0);
      acc(1, REG_OUTPUT_CONTROL, 8'ha0, RESP_OKAY);
      wt(video_osc_sel, 1'b1);
      @(posedge aclk);
      power_down_n <= '0;
      repeat (8) @(posedge aclk);
      #1;
      chk({lock_oe, data_oe, video_oe, remote_irq_input_n_oe},
          4'h1, "pd");
      // Second reset with the fast-rate strap high
      @(posedge aclk);
      strap_mode_select <= '1;
      aresetn <= '0;
      repeat (4) @(posedge aclk);
      aresetn <= '1;
      repeat (2) begin
         wt(bc_bit_tick, 1'b1);
         wt(bc_bit_tick, 1'b0);
      end
      wt(bc_bit_tick, 1'b1);
      chk(n + 1, 5, "strap");
      report_and_stop;
   end
endmodule // dsgb_bench
`default_nettype wire
